/* File: hdl/dpit_target.sv */
`timescale 1ns/10ps
module dpit_target
(
    // Core clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Link clock
    input wire logic link_clk,
    // Serial bus pins
    input wire dpit_pkg::dpit_pin_in_t pin_i,
    output dpit_pkg::dpit_pin_out_t pin_o,
    // Boot configuration and strap converter
    input wire dpit_pkg::dpit_cfg_t cfg_i,
    input wire logic [dpit_pkg::STRAP_CODE_W-1:0] strap_code,
    input wire logic strap_valid,
    output logic boot_done,
    // User side byte port
    output logic evt_valid,
    input wire logic evt_ready,
    output dpit_pkg::dpit_evt_t evt,
    input wire logic [7:0] tx_byte
);
    import dpit_pkg::*;

    dpit_link_t l_q;
    dpit_link_t l_d;
    dpit_core_t c_q;
    dpit_core_t c_d;

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic hit1;
    logic hit2;
    logic outstanding;
    logic [2:0] strap_bits;

    // ----------------------------------------
    // Bus condition decode
    // ----------------------------------------
    assign scl_rise = l_q.filt[0] & ~l_q.prev[0];
    assign scl_fall = ~l_q.filt[0] & l_q.prev[0];
    assign start = l_q.filt[0] & l_q.prev[0] & l_q.prev[1] & ~l_q.filt[1];
    assign stop = l_q.filt[0] & l_q.prev[0] & ~l_q.prev[1] & l_q.filt[1];
    assign hit1 = l_q.rdy_s2 && c_q.en && (l_q.sh[7:1] == c_q.addr1);
    assign hit2 = l_q.rdy_s2 && c_q.en && (l_q.sh[7:1] == c_q.addr2);
    assign outstanding = l_q.req_t ^ l_q.ack_s2;
    assign strap_bits = strap_code[STRAP_BITS_LSB +: 3];

    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    always_comb
    begin
        l_d = l_q;
        l_d.pin_s1 = {pin_i.sda, pin_i.scl};
        l_d.pin_s2 = l_q.pin_s1;
        l_d.rdy_s1 = c_q.rdy;
        l_d.rdy_s2 = l_q.rdy_s1;
        l_d.ack_s1 = c_q.ack_t;
        l_d.ack_s2 = l_q.ack_s1;
        for (int i = 0; i < 2; i++)
        begin
            if (l_q.pin_s2[i] == l_q.filt[i])
            begin
                l_d.cnt[i] = '0;
            end
            else if (l_q.cnt[i] >= DEGLITCH_CYC - 5'd1)
            begin
                l_d.filt[i] = l_q.pin_s2[i];
                l_d.cnt[i] = '0;
            end
            else
            begin
                l_d.cnt[i] = l_q.cnt[i] + 5'd1;
            end
        end
        l_d.prev = l_q.filt;
        if (stop)
        begin
            l_d.st = DPIT_IDLE;
            l_d.sda_drv = 1'b0;
            l_d.scl_hold = 1'b0;
        end
        else if (start)
        begin
            l_d.st = DPIT_ADDR;
            l_d.bitcnt = '0;
            l_d.sda_drv = 1'b0;
            l_d.scl_hold = 1'b0;
        end
        else
        begin
            unique case (l_q.st)
                DPIT_IDLE, DPIT_IGNORE:
                begin
                    l_d.sda_drv = 1'b0;
                end
                DPIT_ADDR, DPIT_WR:
                begin
                    if (scl_rise)
                    begin
                        l_d.sh = {l_q.sh[6:0], l_q.filt[1]};
                        l_d.bitcnt = l_q.bitcnt + 4'd1;
                    end
                    else if (scl_fall && l_q.bitcnt == BITS_PER_BYTE)
                    begin
                        if (l_q.st == DPIT_WR)
                        begin
                            l_d.st = DPIT_RXWAIT;
                            l_d.scl_hold = 1'b1;
                            l_d.sent = 1'b0;
                        end
                        else if (hit1 || hit2)
                        begin
                            l_d.sda_drv = 1'b1;
                            l_d.st = DPIT_ACK_A;
                            l_d.port2 = hit2 && !hit1;
                            l_d.rw = l_q.sh[0];
                            l_d.first = 1'b1;
                        end
                        else
                        begin
                            l_d.st = DPIT_IGNORE;
                        end
                    end
                end
                DPIT_ACK_A:
                begin
                    if (scl_fall)
                    begin
                        l_d.sda_drv = 1'b0;
                        l_d.bitcnt = '0;
                        if (l_q.rw)
                        begin
                            l_d.st = DPIT_TXWAIT;
                            l_d.scl_hold = 1'b1;
                            l_d.sent = 1'b0;
                        end
                        else
                        begin
                            l_d.st = DPIT_WR;
                        end
                    end
                end
                DPIT_RXWAIT, DPIT_TXWAIT:
                begin
                    if (!l_q.sent && !outstanding)
                    begin
                        // first byte flagged as register number
                        l_d.req_t = ~l_q.req_t;
                        l_d.sent = 1'b1;
                        l_d.evt = '{tx_req: l_q.st == DPIT_TXWAIT, port2: l_q.port2,
                                    first: l_q.first, data: l_q.sh};
                    end
                    else if (l_q.sent && !outstanding)
                    begin
                        l_d.tmr = SETUP_CYC;
                        l_d.bitcnt = '0;
                        if (l_q.st == DPIT_RXWAIT)
                        begin
                            l_d.sda_drv = 1'b1;
                            l_d.st = DPIT_ACK_W;
                        end
                        else
                        begin
                            l_d.sh = c_q.tx_data;
                            l_d.sda_drv = ~c_q.tx_data[7];
                            l_d.st = DPIT_RD;
                        end
                    end
                end
                DPIT_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        l_d.sda_drv = 1'b0;
                        l_d.st = DPIT_WR;
                        l_d.bitcnt = '0;
                        l_d.first = 1'b0;
                    end
                end
                DPIT_RD:
                begin
                    if (scl_fall)
                    begin
                        if (l_q.bitcnt == BITS_PER_BYTE - 4'd1)
                        begin
                            l_d.sda_drv = 1'b0;
                            l_d.st = DPIT_ACK_R;
                        end
                        else
                        begin
                            l_d.bitcnt = l_q.bitcnt + 4'd1;
                            l_d.sh = {l_q.sh[6:0], 1'b0};
                            l_d.sda_drv = ~l_q.sh[6];
                        end
                    end
                end
                DPIT_ACK_R:
                begin
                    if (scl_rise)
                    begin
                        l_d.nack = l_q.filt[1];
                    end
                    else if (scl_fall)
                    begin
                        if (l_q.nack)
                        begin
                            l_d.st = DPIT_IGNORE;
                        end
                        else
                        begin
                            l_d.st = DPIT_TXWAIT;
                            l_d.scl_hold = 1'b1;
                            l_d.sent = 1'b0;
                        end
                    end
                end
                default:
                begin
                    l_d.st = DPIT_IDLE;
                    l_d.sda_drv = 1'b0;
                    l_d.scl_hold = 1'b0;
                end
            endcase
            // setup sized for fast mode
            // Data must settle before SCL is let go
            if ((l_q.st == DPIT_ACK_W || l_q.st == DPIT_RD) && l_q.scl_hold)
            begin
                if (l_q.tmr == '0)
                begin
                    l_d.scl_hold = 1'b0;
                end
                else
                begin
                    l_d.tmr = l_q.tmr - 5'd1;
                end
            end
        end
    end

    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
        begin
            l_q <= '{pin_s1: 2'b11, pin_s2: 2'b11, filt: 2'b11, prev: 2'b11, st: DPIT_IDLE, default: '0};
        end
        else
        begin
            l_q <= l_d;
        end
    end

    assign pin_o = '{scl_o: 1'b0, scl_oe: l_q.scl_hold, sda_o: 1'b0, sda_oe: l_q.sda_drv};

    // ----------------------------------------
    // Core domain
    // ----------------------------------------
    always_comb
    begin
        c_d = c_q;
        c_d.req_s1 = l_q.req_t;
        c_d.req_s2 = c_q.req_s1;
        if (!c_q.rdy && (strap_valid || cfg_i.second_port))
        begin
            c_d.rdy = 1'b1;
            c_d.en = cfg_i.second_port || cfg_i.dual_role_target;
            if (cfg_i.second_port)
            begin
                c_d.addr1 = FIXED_P1_ADDR;
                c_d.addr2 = FIXED_P2_ADDR;
            end
            else
            begin
                // strap sets bits three to one
                c_d.addr1 = DUAL_P1_BASE ^ {3'h0, strap_bits, 1'b0};
                c_d.addr2 = DUAL_P2_BASE ^ {3'h0, strap_bits, 1'b0};
            end
        end
        if (c_q.evt_valid && evt_ready)
        begin
            c_d.evt_valid = 1'b0;
            c_d.tx_data = tx_byte;
            c_d.ack_t = c_q.req_seen;
        end
        else if (c_q.req_s2 != c_q.req_seen)
        begin
            // Link holds evt stable until answered
            c_d.evt_valid = 1'b1;
            c_d.evt = l_q.evt;
            c_d.req_seen = c_q.req_s2;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            c_q <= '0;
        end
        else
        begin
            c_q <= c_d;
        end
    end

    assign boot_done = c_q.rdy;
    assign evt_valid = c_q.evt_valid;
    assign evt = c_q.evt;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_addr_done;
        scl_fall && !start && !stop && l_q.st == DPIT_ADDR && l_q.bitcnt == BITS_PER_BYTE;
    endsequence

    sequence s_rx_go;
        !start && !stop && l_q.st == DPIT_RXWAIT && l_q.sent && !outstanding;
    endsequence

    property p_addr_ack;
        @(posedge link_clk) disable iff (reset)
        s_addr_done ##0 (hit1 || hit2) |=> l_q.st == DPIT_ACK_A && pin_o.sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address match not acknowledged");

    property p_addr_miss;
        @(posedge link_clk) disable iff (reset)
        s_addr_done ##0 !(hit1 || hit2) |=> l_q.st == DPIT_IGNORE && !pin_o.sda_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

    property p_port_sel;
        @(posedge link_clk) disable iff (reset)
        s_addr_done ##0 (hit2 && !hit1) |=> l_q.port2;
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("second address did not pick port two");

    property p_boot_gate;
        @(posedge link_clk) disable iff (reset)
        pin_o.sda_oe && l_q.st == DPIT_ACK_A |-> l_q.rdy_s2 && c_q.rdy;
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("acknowledge before boot");

    property p_stop_idle;
        @(posedge link_clk) disable iff (reset)
        stop |=> l_q.st == DPIT_IDLE && !pin_o.sda_oe && !pin_o.scl_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle the target");

    property p_start_addr;
        @(posedge link_clk) disable iff (reset)
        start && !stop |=> l_q.st == DPIT_ADDR && l_q.bitcnt == 4'd0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start did not restart address");

    property p_rx_ack;
        @(posedge link_clk) disable iff (reset)
        s_rx_go |=> l_q.st == DPIT_ACK_W && pin_o.sda_oe && pin_o.scl_oe;
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("received byte not acknowledged");

    property p_tx_release;
        @(posedge link_clk) disable iff (reset)
        l_q.st == DPIT_ACK_R |-> !pin_o.sda_oe;
    endproperty
    a_tx_release: assert property (p_tx_release) else $error("SDA held in master acknowledge slot");

    property p_nack_free;
        @(posedge link_clk) disable iff (reset)
        scl_fall && !start && !stop && l_q.st == DPIT_ACK_R && l_q.nack |=> l_q.st == DPIT_IGNORE ##1 !pin_o.sda_oe;
    endproperty
    a_nack_free: assert property (p_nack_free) else $error("SDA not released after not-acknowledge");

    property p_stretch;
        @(posedge link_clk) disable iff (reset)
        $changed(l_q.req_t) |-> pin_o.scl_oe ##1 (pin_o.scl_oe || stop || start);
    endproperty
    a_stretch: assert property (p_stretch) else $error("SCL not held while waiting");

    property p_evt_hold;
        @(posedge mclk) disable iff (reset)
        evt_valid && !evt_ready |=> evt_valid && $stable(evt);
    endproperty
    a_evt_hold: assert property (p_evt_hold) else $error("byte event dropped before accept");

endmodule : dpit_target

/* File: hdl/dpit_pkg.sv */
package dpit_pkg;

    // ----------------------------------------
    // Addresses
    // ----------------------------------------
    localparam logic [6:0] DUAL_P1_BASE = 7'h20;
    localparam logic [6:0] DUAL_P2_BASE = 7'h24;
    localparam logic [6:0] FIXED_P1_ADDR = 7'h38;
    localparam logic [6:0] FIXED_P2_ADDR = 7'h3F;
    localparam int STRAP_CODE_W = 8;
    localparam int STRAP_BITS_LSB = 5;

    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    localparam int LINK_PERIOD_PS = 12000;
    localparam int SPIKE_NS = 50;
    localparam int DATA_SETUP_NS = 250;
    // Longest spike to reject rounds down
    localparam logic [4:0] DEGLITCH_CYC = 5'(SPIKE_NS * 1000 / LINK_PERIOD_PS);
    // Least setup time rounds up
    localparam logic [4:0] SETUP_CYC = 5'((DATA_SETUP_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        DPIT_IDLE = 4'h0,
        DPIT_ADDR = 4'h1,
        DPIT_ACK_A = 4'h3,
        DPIT_WR = 4'h2,
        DPIT_RXWAIT = 4'h6,
        DPIT_ACK_W = 4'h7,
        DPIT_TXWAIT = 4'h5,
        DPIT_RD = 4'h4,
        DPIT_ACK_R = 4'hC,
        DPIT_IGNORE = 4'h8
    } dpit_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } dpit_pin_in_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } dpit_pin_out_t;

    typedef struct packed {
        logic second_port;
        logic dual_role_target;
    } dpit_cfg_t;

    typedef struct packed {
        logic tx_req;
        logic port2;
        logic first;
        logic [7:0] data;
    } dpit_evt_t;

    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] filt;
        logic [1:0] prev;
        logic [1:0][4:0] cnt;
        logic rdy_s1;
        logic rdy_s2;
        logic ack_s1;
        logic ack_s2;
        dpit_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic rw;
        logic port2;
        logic first;
        logic nack;
        logic sent;
        logic req_t;
        logic [4:0] tmr;
        logic sda_drv;
        logic scl_hold;
        dpit_evt_t evt;
    } dpit_link_t;

    typedef struct packed {
        logic rdy;
        logic en;
        logic [6:0] addr1;
        logic [6:0] addr2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_t;
        logic evt_valid;
        dpit_evt_t evt;
        logic [7:0] tx_data;
    } dpit_core_t;

endpackage : dpit_pkg

/* File: tb/dpit_ctrl_model.sv */
`timescale 1ns/10ps
module dpit_ctrl_model
(
    // Resolved bus wires
    input wire logic scl,
    input wire logic sda,
    // Open-drain pulls, high pulls the wire low
    output logic scl_low,
    output logic sda_low
);
    int hp = 1250;
    int timeouts = 0;

    initial
    begin
        scl_low = 1'h0;
        sda_low = 1'h0;
    end

    task automatic rise();
        int i;
        scl_low = 1'h0;
        for (i = 0; i < 50000 && scl !== 1'h1; i++)
            #10;
        if (scl !== 1'h1)
            timeouts++;
    endtask : rise

    // change only while low, full high time after release
    task automatic pulse(output logic b);
        #(3 * hp / 4);
        rise();
        #(hp / 2);
        b = sda;
        #(hp / 2);
        scl_low = 1'h1;
        #(hp / 4);
    endtask : pulse

    // fall of SDA with SCL high, once the bus is free
    task automatic start();
        int i;
        sda_low = 1'h0;
        #(hp / 4);
        rise();
        for (i = 0; i < 1000 && sda !== 1'h1; i++)
            #10;
        #(hp / 2);
        sda_low = 1'h1;
        #(hp / 2);
        scl_low = 1'h1;
        #(hp / 4);
    endtask : start

    // rise of SDA with SCL high
    task automatic stop();
        sda_low = 1'h1;
        #(hp / 2);
        rise();
        #(hp / 2);
        sda_low = 1'h0;
        #(hp);
    endtask : stop

    task automatic bits(logic [7:0] v, int n);
        logic b;
        for (int k = n - 1; k >= 0; k--)
        begin
            sda_low = !v[k];
            pulse(b);
        end
    endtask : bits

    // release SDA for the target's acknowledge
    task automatic wbyte(logic [7:0] v, output logic ack);
        logic b;
        bits(v, 8);
        sda_low = 1'h0;
        pulse(b);
        ack = !b;
    endtask : wbyte

    // acknowledge every byte but the last
    task automatic rbyte(logic last, output logic [7:0] v);
        logic b;
        sda_low = 1'h0;
        for (int k = 0; k < 8; k++)
        begin
            pulse(b);
            v = {v[6:0], b};
        end
        sda_low = !last;
        pulse(b);
        sda_low = 1'h0;
    endtask : rbyte
endmodule : dpit_ctrl_model

/* File: tb/dpit_target_tb.sv */
`timescale 1ns/10ps
module dpit_target_tb;
    import dpit_pkg::*;
    logic mclk, reset, link_clk, strap_valid, boot_done, evt_valid, evt_ready;
    logic scl_low, sda_low, ack, stretch_seen;
    dpit_pin_in_t pin_i;
    dpit_pin_out_t pin_o;
    dpit_cfg_t cfg_i;
    dpit_evt_t evt;
    logic [7:0] strap_code, tx_byte, rv, base;
    logic [7:0] tx_cnt = 8'h00;
    logic [6:0] a1, a2;
    wire logic scl_w = !(scl_low || pin_o.scl_oe);
    wire logic sda_w = !(sda_low || pin_o.sda_oe);
    dpit_evt_t ev_q[$];
    int num_errors = 0;
    int n_checks = 0;

    assign pin_i = {scl_w, sda_w};
    always #4 mclk = ~mclk;

    initial
    begin
        link_clk = 1'h0;
        #2.7;
        forever #6 link_clk = ~link_clk;
    end

    dpit_target dut (.mclk(mclk), .reset(reset), .link_clk(link_clk), .pin_i(pin_i), .pin_o(pin_o),
        .cfg_i(cfg_i), .strap_code(strap_code), .strap_valid(strap_valid), .boot_done(boot_done),
        .evt_valid(evt_valid), .evt_ready(evt_ready), .evt(evt), .tx_byte(tx_byte));

    dpit_ctrl_model ctrl (.scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));

    // ----------------------------------------
    // User side: accept every event at once
    // ----------------------------------------
    always @(negedge mclk)
    begin
        evt_ready <= evt_valid;
        tx_byte <= 8'h96 ^ tx_cnt;
    end

    always @(posedge mclk)
    begin
        if (pin_o.scl_oe === 1'h1)
            stretch_seen <= 1'h1;
        if (evt_valid === 1'h1 && evt_ready === 1'h1)
        begin
            ev_q.push_back(evt);
            if (evt.tx_req)
                tx_cnt <= tx_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Compare and closing tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_evt(logic txr, logic p2, logic fst, logic [7:0] d);
        dpit_evt_t e;
        chk("event count", 8'h01, {7'h00, ev_q.size() != 0});
        if (ev_q.size() != 0)
        begin
            e = ev_q.pop_front();
            chk("event tx_req", {7'h00, txr}, {7'h00, e.tx_req});
            chk("event port2", {7'h00, p2}, {7'h00, e.port2});
            if (!txr)
            begin
                chk("event first", {7'h00, fst}, {7'h00, e.first});
                chk("event data", d, e.data);
            end
        end
    endtask : chk_evt

    task automatic conclude();
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic strap_pulse();
        @(negedge mclk);
        strap_valid = 1'h1;
        @(negedge mclk);
        strap_valid = 1'h0;
        repeat (30) @(negedge mclk);
    endtask : strap_pulse

    task automatic boot(dpit_cfg_t c, logic sv);
        @(negedge mclk);
        reset = 1'h1;
        cfg_i = c;
        repeat (16) @(negedge mclk);
        reset = 1'h0;
        ev_q.delete();
        if (sv)
            strap_pulse();
        repeat (30) @(negedge mclk);
    endtask : boot

    // One register-number write; a refused address must leave no event
    task automatic wr1(logic [6:0] a, logic [7:0] d, logic exp, logic p2);
        ctrl.start();
        ctrl.wbyte({a, 1'h0}, ack);
        chk("address ack", {7'h00, exp}, {7'h00, ack});
        ctrl.wbyte(d, ack);
        chk("data ack", {7'h00, exp}, {7'h00, ack});
        ctrl.stop();
        if (exp)
            chk_evt(1'h0, p2, 1'h1, d);
        else
            chk("events left", 8'h00, 8'(ev_q.size()));
    endtask : wr1

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_preboot();
        a1 = DUAL_P1_BASE ^ {3'h0, strap_code[7:5], 1'h0};
        a2 = DUAL_P2_BASE ^ {3'h0, strap_code[7:5], 1'h0};
        boot(2'h1, 1'h0);
        wr1(a1, 8'h11, 1'h0, 1'h0);
        chk("boot before strap", 8'h00, {7'h00, boot_done});
        strap_pulse();
        chk("boot after strap", 8'h01, {7'h00, boot_done});
        chk("open drain values", 8'h00, {6'h00, pin_o.scl_o, pin_o.sda_o});
    endtask : t_preboot

    task automatic t_write();
        logic [7:0] wd [3] = '{8'h5A, 8'h01, 8'hC3};
        stretch_seen = 1'h0;
        ctrl.start();
        ctrl.wbyte({a1, 1'h0}, ack);
        chk("address ack", 8'h01, {7'h00, ack});
        for (int i = 0; i < 3; i++)
        begin
            ctrl.wbyte(wd[i], ack);
            chk("data ack", 8'h01, {7'h00, ack});
        end
        ctrl.stop();
        for (int i = 0; i < 3; i++)
            chk_evt(1'h0, 1'h0, i == 0, wd[i]);
        chk("stretch seen", 8'h01, {7'h00, stretch_seen});
    endtask : t_write

    task automatic t_read();
        base = tx_cnt;
        ctrl.start();
        ctrl.wbyte({a2, 1'h0}, ack);
        ctrl.wbyte(8'h07, ack);
        ctrl.start();
        ctrl.wbyte({a2, 1'h1}, ack);
        chk("read address ack", 8'h01, {7'h00, ack});
        ctrl.rbyte(1'h0, rv);
        chk("read byte 0", 8'h96 ^ base, rv);
        ctrl.rbyte(1'h1, rv);
        chk("read byte 1", 8'h96 ^ (base + 8'h01), rv);
        chk("sda after nack", 8'h00, {7'h00, pin_o.sda_oe});
        ctrl.stop();
        chk_evt(1'h0, 1'h1, 1'h1, 8'h07);
        chk_evt(1'h1, 1'h1, 1'h0, 8'h00);
        chk_evt(1'h1, 1'h1, 1'h0, 8'h00);
        chk("events left", 8'h00, 8'(ev_q.size()));
    endtask : t_read

    task automatic t_reject();
        ctrl.hp = 5000;
        wr1(a2, 8'h3C, 1'h1, 1'h1);
        ctrl.hp = 1250;
        wr1(7'h11, 8'hA5, 1'h0, 1'h0);
        ctrl.start();
        ctrl.bits(8'h0F, 4);
        wr1(a1, 8'h44, 1'h1, 1'h0);
    endtask : t_reject

    task automatic t_roles();
        boot(2'h2, 1'h0);
        wr1(FIXED_P1_ADDR, 8'h61, 1'h1, 1'h0);
        wr1(FIXED_P2_ADDR, 8'h62, 1'h1, 1'h1);
        wr1(a1, 8'h63, 1'h0, 1'h0);
        boot(2'h0, 1'h1);
        wr1(a1, 8'h64, 1'h0, 1'h0);
    endtask : t_roles

    initial
    begin
        mclk = 1'h0;
        reset = 1'h1;
        cfg_i = 2'h0;
        strap_code = 8'hA0;
        strap_valid = 1'h0;
        evt_ready = 1'h0;
        tx_byte = 8'h00;
        t_preboot();
        t_write();
        t_read();
        t_reject();
        t_roles();
        chk("stretch timeouts", 8'h00, 8'(ctrl.timeouts));
        conclude();
    end

    // Run needs about 770 us of bus traffic
    initial
    begin
        #900000;
        num_errors++;
        conclude();
    end
endmodule : dpit_target_tb
